// ---- logic/sld_top.sv ----
// Serial lane deserializer: lanes plus link clock in, parallel word and strobe clock out
`timescale 1ns/1ps
module sld_top
    import sld_pkg::*;
#(
    parameter int LANES    = WIDE_LANES,
    parameter int LOCK_CYC = LOCK_WAIT_CYC
) (
    input  wire logic                              i_clk,
    input  wire logic                              i_rstn,
    input  wire logic [LANES-1:0]                  i_serial_lane_in,
    input  wire logic [LANES-1:0]                  i_lane_driven,
    input  wire logic                              i_link_clock_in,
    input  wire logic                              i_sleep_n,
    output logic [LANES*SLOTS_PER_PERIOD-1:0]      o_parallel_word_out,
    output logic                                   o_strobe_clock_out,
    output logic                                   o_lock_done
);
    localparam int WORD_W      = LANES * SLOTS_PER_PERIOD;
    localparam int SYNC_W      = 2 * LANES + 2;
    localparam int SLEEP_BOUND = 40;

    // Slot k is due once the phase passes the middle of its slot
    function automatic logic slot_due(input logic [15:0] ph, input logic [2:0] k, input logic [15:0] per);
        logic [23:0] lhs;
        logic [23:0] rhs;
        lhs = 24'(ph) * SLOT_SCALE + SLOT_CENTRE;
        rhs = (24'(k) * 24'h00_0002 + 24'h00_0001) * 24'(per);
        return lhs >= rhs;
    endfunction : slot_due

    logic [SYNC_W-1:0]  sync_out;
    logic [LANES-1:0]   lane_s;
    logic [LANES-1:0]   driven_s;
    logic               link_s;
    logic               sleep_n_s;
    logic               link_prev_r;
    logic               link_rise;
    logic               link_dead;
    logic [15:0]        ph_r;
    logic [15:0]        per_r;
    logic               per_ok_r;
    logic [2:0]         slot_r;
    logic               take;
    logic [LANES-1:0]   lane_bit;
    logic [WORD_W-1:0]  cap_r;
    logic [WORD_W-1:0]  pend_r;
    logic               pend_ok_r;
    logic [31:0]        lock_cnt_r;
    sld_state_t         state_r;
    sld_state_t         state_nxt;

    // Every outside input except i_rstn crosses two flops before use
    sld_sync #(.WIDTH(SYNC_W)) u_sync (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_async({i_sleep_n, i_link_clock_in, i_lane_driven, i_serial_lane_in}),
        .o_sync (sync_out)
    );
    assign lane_s    = sync_out[LANES-1:0];
    assign driven_s  = sync_out[2*LANES-1:LANES];
    assign link_s    = sync_out[2*LANES];
    assign sleep_n_s = sync_out[2*LANES+1];

    // Link edge detection on the synchronised copy only
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            link_prev_r <= 1'b0;
        else
            link_prev_r <= link_s;
    end
    assign link_rise = link_s & ~link_prev_r;
    assign link_dead = (ph_r >= LINK_DEAD_CYC);

    // Phase within the link period and measured period; periods of up to 256 block cycles are tracked
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ph_r     <= PH_RST;
            per_r    <= PER_RST;
            per_ok_r <= 1'b0;
        end
        else if (state_r == ST_SLEEP)
        begin
            ph_r     <= PH_RST;
            per_ok_r <= 1'b0;
        end
        else if (link_rise)
        begin
            ph_r     <= PH_RST;
            per_r    <= ph_r + 16'h0001;
            per_ok_r <= !link_dead;
        end
        else if (!link_dead)
        begin
            ph_r <= ph_r + 16'h0001;
        end
        else
        begin
            per_ok_r <= 1'b0;
        end
    end

    // Undriven lanes float high through the failsafe bias
    assign lane_bit = lane_s | ~driven_s;
    assign take     = per_ok_r && (slot_r != SLOTS_DONE) && slot_due(ph_r, slot_r, per_r);

    // Slots are taken in order, bit 0 first, at successive slot centres
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            slot_r <= SLOT_RST;
            cap_r  <= '0;
        end
        else if (state_r == ST_SLEEP)
        begin
            slot_r <= SLOT_RST;
            cap_r  <= '0;
        end
        else if (link_rise)
        begin
            slot_r <= SLOT_RST;
        end
        else if (take)
        begin
            // Lane n owns bits n*7 .. n*7+6 of the word
            for (int n = 0; n < LANES; n++)
                cap_r[n*SLOTS_PER_PERIOD + int'(slot_r)] <= lane_bit[n];
            slot_r <= slot_r + 3'h1;
        end
    end

    // Operating state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_SLEEP: if (sleep_n_s) state_nxt = ST_LOCK;
            ST_LOCK:  if (link_dead) state_nxt = ST_LOST;
                      else if (lock_cnt_r >= 32'(LOCK_CYC - 1)) state_nxt = ST_RUN;
            ST_RUN:   if (link_dead) state_nxt = ST_LOST;
            ST_LOST:  if (link_rise) state_nxt = ST_LOCK;
            default:  state_nxt = ST_SLEEP;
        endcase
        if (!sleep_n_s)
            state_nxt = ST_SLEEP;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            state_r <= ST_SLEEP;
        else
            state_r <= state_nxt;
    end

    // Lock wait restarts whenever the clock returns or sleep ends
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            lock_cnt_r <= '0;
        else if (state_r == ST_LOCK)
            lock_cnt_r <= lock_cnt_r + 32'h0000_0001;
        else
            lock_cnt_r <= '0;
    end

    // Two-stage word pipe: capture, pend, present; one step per link edge
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pend_r              <= '0;
            pend_ok_r           <= 1'b0;
            o_parallel_word_out <= '0;
        end
        else if (state_nxt == ST_SLEEP)
        begin
            pend_r              <= '0;
            pend_ok_r           <= 1'b0;
            o_parallel_word_out <= '0;
        end
        else if (link_rise && state_r != ST_LOST)
        begin
            pend_r    <= cap_r;
            pend_ok_r <= per_ok_r && (slot_r == SLOTS_DONE);
            // Only a whole word reaches the pins, and only after lock
            if (state_r == ST_RUN && pend_ok_r)
                o_parallel_word_out <= pend_r;
        end
        // With the link clock gone the word simply stays put
    end

    // Strobe clock high for the second half of the measured period
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_strobe_clock_out <= 1'b0;
        else
            o_strobe_clock_out <= (state_nxt == ST_RUN) && per_ok_r && !link_rise &&
                                  (ph_r + 16'h0001 >= (per_r >> 1));
    end

    // Lock indication for downstream logic
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_lock_done <= 1'b0;
        else
            o_lock_done <= (state_nxt == ST_RUN);
    end

    a_sleep_low: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (!sleep_n_s && !$past(sleep_n_s)) |-> (o_parallel_word_out == '0 && !o_strobe_clock_out && !o_lock_done))
        else $error("outputs not low in sleep");

    a_sleep_entry_time: assert property (@(posedge i_clk) disable iff (!i_rstn)
        $fell(i_sleep_n) |-> ##[1:SLEEP_BOUND] (o_parallel_word_out == '0 && !o_strobe_clock_out))
        else $error("sleep entry too slow");

    a_lock_wait_full: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (state_r == ST_RUN && $past(state_r) == ST_LOCK) |-> $past(lock_cnt_r) == 32'(LOCK_CYC - 1))
        else $error("run entered before lock wait");

    a_word_once_period: assert property (@(posedge i_clk) disable iff (!i_rstn)
        ($changed(o_parallel_word_out) && sleep_n_s && $past(sleep_n_s)) |-> $past(link_rise))
        else $error("word changed off a link edge");

    a_word_pipe_latency: assert property (@(posedge i_clk) disable iff (!i_rstn)
        ($changed(o_parallel_word_out) && sleep_n_s && $past(sleep_n_s)) |-> o_parallel_word_out == $past(pend_r))
        else $error("word skipped the pipe stage");

    a_dead_hold_word: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (state_r == ST_LOST && sleep_n_s && $past(sleep_n_s)) |=> $stable(o_parallel_word_out))
        else $error("word moved with link clock gone");

    a_dead_strobe_low: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (state_r == ST_LOST) |=> !o_strobe_clock_out)
        else $error("strobe active with link clock gone");

    a_float_reads_high: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (take && driven_s[0] == 1'b0 && state_r != ST_SLEEP && !link_rise) |=> cap_r[int'($past(slot_r))] == 1'b1)
        else $error("undriven lane not read high");

    a_slot_order: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (slot_r != $past(slot_r) && slot_r != SLOT_RST) |-> slot_r == $past(slot_r) + 3'h1)
        else $error("slots taken out of order");

    a_strobe_rise_mid: assert property (@(posedge i_clk) disable iff (!i_rstn)
        $rose(o_strobe_clock_out) |-> ($past(ph_r) + 16'h0001 >= ($past(per_r) >> 1)))
        else $error("strobe rose before mid period");
endmodule : sld_top

// ---- logic/sld_pkg.sv ----
// Shared constants for the serial lane deserializer
package sld_pkg;
    // Clock rate of the block's own clock
    localparam int CLK_MHZ            = 40;
    localparam int CLK_PERIOD_NS      = 25;
    // Bit slots carried by each lane in one link clock period
    localparam int SLOTS_PER_PERIOD   = 7;
    localparam logic [2:0] LAST_SLOT  = 3'h6;
    localparam logic [2:0] SLOTS_DONE = 3'h7;
    // Lane counts of the wide and narrow variants
    localparam int WIDE_LANES         = 4;
    localparam int NARROW_LANES       = 3;
    // Lock wait after a clock returns or sleep ends, in microseconds
    localparam int LOCK_WAIT_US       = 10000;
    localparam int LOCK_WAIT_CYC      = LOCK_WAIT_US * CLK_MHZ;
    // Longest allowed sleep entry delay
    localparam int SLEEP_ENTRY_NS     = 1000;
    localparam int SLEEP_ENTRY_CYC    = (SLEEP_ENTRY_NS / CLK_PERIOD_NS < 1) ? 1 : SLEEP_ENTRY_NS / CLK_PERIOD_NS;
    // Clock pass delay, picoseconds; below one cycle, so one cycle is the floor
    localparam int CLOCK_PASS_DELAY_PS = 7500;
    localparam int CLOCK_PASS_CYC     = (CLOCK_PASS_DELAY_PS * CLK_MHZ / 1000000 < 1) ? 1 :
                                        CLOCK_PASS_DELAY_PS * CLK_MHZ / 1000000;
    // Link periods of latency through the receiver
    localparam int LATENCY_PERIODS    = 2;
    // Cycles without a link edge before the link clock counts as gone
    localparam logic [15:0] LINK_DEAD_CYC = 16'h0100;
    // Slot sampling: ph*14 + 28 >= (2k+1)*period; the extra two cycles pay back the
    // synchroniser delay and the round-up, so each sample lands near the middle of its slot
    // and slot 6 is always taken before the next link edge
    localparam logic [23:0] SLOT_SCALE  = 24'h00_000E;
    localparam logic [23:0] SLOT_CENTRE = 24'h00_001C;
    // Reset values
    localparam logic [15:0] PH_RST    = 16'h0000;
    localparam logic [15:0] PER_RST   = 16'h0000;
    localparam logic [2:0]  SLOT_RST  = 3'h0;

    // Operating state, one-hot
    typedef enum logic [3:0] {
        ST_SLEEP = 4'b0001,
        ST_LOCK  = 4'b0010,
        ST_RUN   = 4'b0100,
        ST_LOST  = 4'b1000
    } sld_state_t;
endpackage : sld_pkg

// ---- logic/sld_sync.sv ----
// Two-flop synchroniser for a group of level inputs
`timescale 1ns/1ps
module sld_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            meta_r <= '0;
            o_sync <= '0;
        end
        else
        begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule : sld_sync

// ---- verif/sld_tx_model.sv ----
// Behavioural serializing transmitter on the far side of the lanes
`timescale 1ns/1ps
module sld_tx_model
    import sld_pkg::*;
#(
    parameter int  LANES  = WIDE_LANES,
    parameter real PER_NS = 400.0,
    parameter real HI_NS  = 120.0
) (
    input  wire logic [LANES*SLOTS_PER_PERIOD-1:0] i_word,
    input  wire logic                              i_run,
    input  wire logic                              i_float,
    output logic                                   o_link_clock,
    output logic      [LANES-1:0]                  o_lanes,
    output logic      [LANES-1:0]                  o_driven
);
    logic [LANES*SLOTS_PER_PERIOD-1:0] word_r;

    // Lanes released by the far side are flagged undriven
    assign o_driven = {LANES{~i_float}};

    // One frame per period; clock stands low while stopped, duty kept uneven on purpose
    initial
    begin
        o_link_clock = 1'b0;
        o_lanes      = '0;
        forever
        begin
            wait (i_run);
            word_r       = i_word;
            o_link_clock = 1'b1;
            o_link_clock <= #(HI_NS) 1'b0;
            for (int k = 0; k < SLOTS_PER_PERIOD; k++)
            begin
                // Bit 0 first; a released lane toggles so no stale level survives
                for (int n = 0; n < LANES; n++)
                    o_lanes[n] = i_float ? ~o_lanes[n] : word_r[n*SLOTS_PER_PERIOD+k];
                #(PER_NS / 7.0);
            end
        end
    end
endmodule : sld_tx_model

// ---- verif/sld_top_test.sv ----
// Self-checking bench for the deserializer, wide and narrow variants side by side
`timescale 1ns/1ps
module sld_top_test;
    import sld_pkg::*;
    localparam int  W    = WIDE_LANES*SLOTS_PER_PERIOD;
    localparam int  N    = NARROW_LANES*SLOTS_PER_PERIOD;
    localparam int  LOCK = 50;
    localparam real PER  = 400.0;
    typedef struct packed {
        logic [W-1:0] word;
        logic [W-1:0] exp_w;
        logic [N-1:0] exp_n;
    } sld_row_t;
    logic           clk, rstn, sleep_n, run, flt;
    logic [W-1:0]   word, out_w;
    logic [N-1:0]   out_n;
    logic [3:0]     lanes_w, drv_w;
    logic [2:0]     lanes_n, drv_n;
    logic           link_w, link_n, stb_w, stb_n, lock_w, lock_n;
    logic [W-1:0]   got [8];
    int             bad_count, checked, k, hi;
    real            t0;
    sld_row_t       rows [6] = '{
        '{28'h000_0001, 28'h000_0001, 21'h00_0001}, '{28'h000_0040, 28'h000_0040, 21'h00_0040},
        '{28'h020_0000, 28'h020_0000, 21'h00_0000}, '{28'h800_0000, 28'h800_0000, 21'h00_0000},
        '{28'h555_5555, 28'h555_5555, 21'h15_5555}, '{28'hAAA_AAAA, 28'hAAA_AAAA, 21'h0A_AAAA}};

    sld_top #(.LANES(WIDE_LANES), .LOCK_CYC(LOCK)) sld_top_inst (.i_clk(clk), .i_rstn(rstn),
        .i_serial_lane_in(lanes_w), .i_lane_driven(drv_w), .i_link_clock_in(link_w), .i_sleep_n(sleep_n),
        .o_parallel_word_out(out_w), .o_strobe_clock_out(stb_w), .o_lock_done(lock_w));
    sld_top #(.LANES(NARROW_LANES), .LOCK_CYC(LOCK)) sld_top_inst_narrow (.i_clk(clk), .i_rstn(rstn),
        .i_serial_lane_in(lanes_n), .i_lane_driven(drv_n), .i_link_clock_in(link_n), .i_sleep_n(sleep_n),
        .o_parallel_word_out(out_n), .o_strobe_clock_out(stb_n), .o_lock_done(lock_n));
    sld_tx_model #(.LANES(WIDE_LANES)) sld_tx_model_inst (.i_word(word), .i_run(run), .i_float(flt),
        .o_link_clock(link_w), .o_lanes(lanes_w), .o_driven(drv_w));
    sld_tx_model #(.LANES(NARROW_LANES)) sld_tx_model_inst_narrow (.i_word(word[N-1:0]), .i_run(run),
        .i_float(flt), .o_link_clock(link_n), .o_lanes(lanes_n), .o_driven(drv_n));

    // Block clock, 25 ns period
    always #12.5 clk = ~clk;

    task automatic cmp_word(input logic [W-1:0] g, input logic [W-1:0] e);
        checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("FAIL %0t word %h expected %h", $time, g, e);
        end
    endtask : cmp_word

    task automatic cmp_bit(input logic g, input logic e);
        checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("FAIL %0t flag %b expected %b", $time, g, e);
        end
    endtask : cmp_bit

    // Bounded wait for both variants to finish locking; flags a failure if that took fewer than lo cycles
    task automatic wait_lock(input int lo);
        int n;
        n = 0;
        while (!(lock_w === 1'b1 && lock_n === 1'b1) && n < 4000)
        begin
            @(negedge clk);
            n++;
        end
        cmp_bit(n >= lo && n < 4000, 1'b1);
    endtask : wait_lock

    // Holds one word long enough for capture plus two periods of latency
    task automatic hold_row(input sld_row_t r);
        @(negedge clk);
        word = r.word;
        repeat (5) @(posedge link_w);
        @(posedge stb_w);
        @(negedge clk);
        cmp_word(out_w, r.exp_w);
        cmp_word({7'h00, out_n}, {7'h00, r.exp_n});
    endtask : hold_row

    task automatic end_of_test;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    // Cuts a hang short well past the expected run length
    initial
    begin
        #200000;
        bad_count++;
        $display("FAIL %0t watchdog", $time);
        end_of_test();
    end

    initial
    begin
        {clk, rstn, sleep_n, run, flt, word, bad_count, checked} = '0;
        sleep_n = 1'b1;
        run     = 1'b1;
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        repeat (10) @(negedge clk);
        cmp_bit(lock_w | stb_w | (|out_w), 1'b0);
        wait_lock(LOCK - 10);
        foreach (rows[i])
            hold_row(rows[i]);
        $display("table done");
        // Back-to-back words, one per period, must come out in order
        fork
            for (int i = 0; i < 4; i++)
            begin
                @(posedge link_w);
                @(negedge clk);
                word = rows[i].word;
            end
            for (int j = 0; j < 8; j++)
            begin
                @(posedge stb_w);
                @(negedge clk);
                got[j] = out_w;
            end
        join
        k = -1;
        for (int j = 4; j >= 0; j--)
            if (got[j] === rows[0].word)
                k = j;
        cmp_bit(k >= 0, 1'b1);
        if (k >= 0)
            for (int j = 1; j < 4; j++)
                cmp_word(got[k+j], rows[j].word);
        // Strobe high for half the measured period while link duty is 30 percent
        hi = 0;
        @(posedge stb_w);
        repeat (16) @(negedge clk) hi += (stb_w === 1'b1);
        cmp_bit(hi >= 7 && hi <= 9, 1'b1);
        @(posedge link_w);
        @(negedge clk);
        word = 28'h0F0_F0F0;
        @(posedge link_w);
        t0 = $realtime;
        @(out_w);
        cmp_bit($realtime - t0 >= 2 * PER && $realtime - t0 <= 2 * PER + 5 * CLK_PERIOD_NS, 1'b1);
        $display("stream done");
        // Link clock vanishes: word holds, strobe stays low
        repeat (4) @(posedge link_w);
        @(negedge clk);
        run = 1'b0;
        repeat (300) @(negedge clk);
        cmp_word(out_w, 28'h0F0_F0F0);
        hi = 0;
        repeat (32) @(negedge clk) hi |= (stb_w !== 1'b0);
        cmp_bit(hi == 0 && lock_w === 1'b0, 1'b1);
        // Clock returns with every lane released
        flt = 1'b1;
        run = 1'b1;
        wait_lock(LOCK);
        repeat (5) @(posedge link_w);
        @(negedge clk);
        cmp_word(out_w, '1);
        cmp_word({7'h00, out_n}, {7'h00, 21'h1F_FFFF});
        flt = 1'b0;
        $display("loss done");
        sleep_n = 1'b0;
        repeat (SLEEP_ENTRY_CYC) @(negedge clk);
        cmp_word(out_w, '0);
        cmp_bit(stb_w | lock_w | stb_n | (|out_n), 1'b0);
        sleep_n = 1'b1;
        wait_lock(LOCK);
        hold_row(rows[4]);
        $display("sleep done");
        // Reset in mid-run: outputs drop at once and the lock wait starts over
        @(negedge clk);
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        cmp_bit(lock_w | stb_w | (|out_w) | lock_n | stb_n | (|out_n), 1'b0);
        rstn = 1'b1;
        wait_lock(LOCK);
        hold_row(rows[5]);
        $display("reset done");
        end_of_test();
    end
endmodule : sld_top_test
